/* File: shared/hpe_pkg.sv */
// Package with constants, register map and state types of the haptic effect player
package hpe_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned PWM_HZ          = 23_000;
    localparam int unsigned TICK_MS         = 5;
    localparam int unsigned PWM_PERIOD_CYC  = CLK_HZ / PWM_HZ;
    localparam int unsigned TICK_CYC        = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned SVC_DUR_CYC     = 90;
    localparam logic [15:0] PWM_PERIOD      = 16'(PWM_PERIOD_CYC);
    localparam logic [6:0]  SVC_DUR         = 7'(SVC_DUR_CYC);
    localparam int unsigned NUM_EFFECTS     = 14;
    localparam int unsigned STEPS           = 16;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ENABLE   = 8'h04;
    localparam logic [7:0] REG_PLAY     = 8'h08;
    localparam logic [7:0] REG_STATUS   = 8'h0C;
    localparam logic [7:0] REG_UPDATE   = 8'h10;
    localparam logic [7:0] REG_DUTY_BASE = 8'h40;

    // Control field positions
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    localparam logic [13:0] ENABLE_RESET  = 14'h0000;

    // Status field positions
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_REJ  = 1;
    localparam int unsigned ST_STEP = 4;
    localparam int unsigned ST_EFF  = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        HPE_MODE_HW     = 2'b00,
        HPE_MODE_SW     = 2'b01,
        HPE_MODE_DIRECT = 2'b10
    } hpe_mode_e;

    typedef enum logic [1:0] {
        HPE_IDLE = 2'b00,
        HPE_PLAY = 2'b01,
        HPE_SVC  = 2'b10
    } hpe_state_e;
endpackage

/* File: rtl/hpe_player.sv */
// Haptic effect player: PWM generator, effect tick and AXI4-Lite registers
// Functional notes
// - PWM out, duty replaced each update step
// - Fourteen effects, disabled ones unplayable
// - Play request on disabled effect rejected
// - Hardware mode: counters make PWM and tick
// - Software mode: PWM hardware, tick from software
// - Sixteen-bit PWM counter near 23 kHz
// - Tick timer fires every 5 ms
// - Each service event ends within 90 cycles
// - No periodic events while idle
// - Playback runs without processor involvement in hardware mode only
// - Tick interval 5 ms within ten percent
module hpe_player (
    input  wire logic        clk_sys_in,      // System clock, 25 MHz
    input  wire logic        rst_in,          // Async reset, active high
    input  wire logic [7:0]  s_axi_awaddr,    // Write address
    input  wire logic        s_axi_awvalid,   // Write address valid
    output logic             s_axi_awready,   // Write address ready
    input  wire logic [31:0] s_axi_wdata,     // Write data
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
    input  wire logic        s_axi_wvalid,    // Write data valid
    output logic             s_axi_wready,    // Write data ready
    output logic [1:0]       s_axi_bresp,     // Write response
    output logic             s_axi_bvalid,    // Write response valid
    input  wire logic        s_axi_bready,    // Write response ready
    input  wire logic [7:0]  s_axi_araddr,    // Read address
    input  wire logic        s_axi_arvalid,   // Read address valid
    output logic             s_axi_arready,   // Read address ready
    output logic [31:0]      s_axi_rdata,     // Read data
    output logic [1:0]       s_axi_rresp,     // Read response
    output logic             s_axi_rvalid,    // Read data valid
    input  wire logic        s_axi_rready,    // Read data ready
    output logic             duty_compare_output_out,  // PWM to amplifier input
    output logic             amplifier_shutdown_n_out  // Amplifier shutdown, active low
);
    // Register state
    logic [1:0]  mode, next_mode;
    logic [13:0] enable, next_enable;
    logic [7:0]  duty_mem [0:hpe_pkg::STEPS-1];
    logic [7:0]  next_duty_mem [0:hpe_pkg::STEPS-1];
    logic [3:0]  seq_len, next_seq_len;
    logic        rejected, next_rejected;

    // Bus handshake state
    logic        aw_held, next_aw_held;
    logic        w_held, next_w_held;
    logic [7:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0]  rresp, next_rresp;
    logic        aw_rdy, next_aw_rdy;
    logic        w_rdy, next_w_rdy;
    logic        ar_rdy, next_ar_rdy;

    // Player state
    hpe_pkg::hpe_state_e state, next_state;
    logic [3:0]  effect, next_effect;
    logic [3:0]  step, next_step;
    logic [7:0]  duty, next_duty;
    logic [15:0] pwm_cnt, next_pwm_cnt;
    logic [19:0] tick_cnt, next_tick_cnt;
    logic [6:0]  svc_cnt, next_svc_cnt;
    logic        pwm_q, next_pwm_q;
    logic        amp_q, next_amp_q;

    logic        do_write;
    logic        play_req;
    logic        upd_req;
    logic [3:0]  play_sel;
    logic        tick;
    logic [15:0] duty_cmp;

    assign do_write = aw_held && w_held && !bvalid;
    assign play_sel = w_data[3:0];
    assign play_req = do_write && aw_addr == hpe_pkg::REG_PLAY && w_strb[0];
    assign upd_req  = do_write && aw_addr == hpe_pkg::REG_UPDATE && w_strb[0];
    // Duty value scales 0..255 onto the PWM period
    assign duty_cmp = 16'((32'(duty) * 32'(hpe_pkg::PWM_PERIOD)) >> 8);

    // Tick source selection per mode
    always_comb begin
        unique case (hpe_pkg::hpe_mode_e'(mode))
            hpe_pkg::HPE_MODE_HW: tick = tick_cnt == 20'(hpe_pkg::TICK_CYC - 1);
            hpe_pkg::HPE_MODE_SW: tick = upd_req;
            hpe_pkg::HPE_MODE_DIRECT: tick = upd_req;
            default: tick = 1'b0;
        endcase
    end

    // Bus slave next state
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_mode    = mode;
        next_enable  = enable;
        next_seq_len = seq_len;
        next_rejected = rejected;
        for (int i = 0; i < int'(hpe_pkg::STEPS); i++) begin
            next_duty_mem[i] = duty_mem[i];
        end
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = hpe_pkg::RESP_OKAY;
            if (aw_addr == hpe_pkg::REG_CTRL) begin
                if (w_strb[0]) next_mode = w_data[1:0];
                if (w_strb[0]) next_seq_len = w_data[7:4];
            end else if (aw_addr == hpe_pkg::REG_ENABLE) begin
                if (w_strb[0]) next_enable[7:0] = w_data[7:0];
                if (w_strb[1]) next_enable[13:8] = w_data[13:8];
            end else if (aw_addr == hpe_pkg::REG_PLAY) begin
                // Reject disabled or out-of-range effects; sticky until next accepted play
                if (w_strb[0]) next_rejected = !(play_sel < 4'(hpe_pkg::NUM_EFFECTS)
                                               && enable[play_sel]);
            end else if (aw_addr == hpe_pkg::REG_UPDATE) begin
                next_bresp = hpe_pkg::RESP_OKAY;
            end else if (aw_addr >= hpe_pkg::REG_DUTY_BASE
                         && aw_addr < 8'(hpe_pkg::REG_DUTY_BASE + 8'h40)
                         && aw_addr[1:0] == 2'h0) begin
                if (w_strb[0]) next_duty_mem[aw_addr[5:2]] = w_data[7:0];
            end else begin
                next_bresp = hpe_pkg::RESP_SLVERR;
            end
        end
        if (bvalid && s_axi_bready) next_bvalid = 1'b0;
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = hpe_pkg::RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (s_axi_araddr == hpe_pkg::REG_CTRL) begin
                next_rdata[7:0] = {seq_len, 2'b00, mode};
            end else if (s_axi_araddr == hpe_pkg::REG_ENABLE) begin
                next_rdata[13:0] = enable;
            end else if (s_axi_araddr == hpe_pkg::REG_STATUS) begin
                next_rdata[hpe_pkg::ST_BUSY] = state != hpe_pkg::HPE_IDLE;
                next_rdata[hpe_pkg::ST_REJ]  = rejected;
                next_rdata[hpe_pkg::ST_STEP +: 4] = step;
                next_rdata[hpe_pkg::ST_EFF +: 4]  = effect;
            end else if (s_axi_araddr == hpe_pkg::REG_PLAY
                         || s_axi_araddr == hpe_pkg::REG_UPDATE) begin
                next_rdata = 32'h0000_0000;
            end else if (s_axi_araddr >= hpe_pkg::REG_DUTY_BASE
                         && s_axi_araddr < 8'(hpe_pkg::REG_DUTY_BASE + 8'h40)
                         && s_axi_araddr[1:0] == 2'h0) begin
                next_rdata[7:0] = duty_mem[s_axi_araddr[5:2]];
            end else begin
                next_rresp = hpe_pkg::RESP_SLVERR;
            end
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        // Readies mirror the holders one edge ahead so the ports leave from flops
        next_aw_rdy = !next_aw_held;
        next_w_rdy  = !next_w_held;
        next_ar_rdy = !next_rvalid;
    end

    // Player next state
    always_comb begin
        next_state    = state;
        next_effect   = effect;
        next_step     = step;
        next_duty     = duty;
        next_pwm_cnt  = pwm_cnt;
        next_tick_cnt = tick_cnt;
        next_svc_cnt  = svc_cnt;
        next_pwm_q    = 1'b0;
        next_amp_q    = 1'b0;
        unique case (state)
            hpe_pkg::HPE_IDLE: begin
                // Counters held at zero while idle so nothing periodic happens
                next_pwm_cnt  = 16'h0000;
                next_tick_cnt = 20'h00000;
                if (play_req && !next_rejected) begin
                    next_state  = hpe_pkg::HPE_PLAY;
                    next_effect = play_sel;
                    next_step   = 4'h0;
                    next_duty   = duty_mem[0];
                end
            end
            hpe_pkg::HPE_PLAY, hpe_pkg::HPE_SVC: begin
                next_amp_q = 1'b1;
                // Free-running period counter, compare against duty
                if (pwm_cnt == hpe_pkg::PWM_PERIOD - 16'h0001) begin
                    next_pwm_cnt = 16'h0000;
                end else begin
                    next_pwm_cnt = pwm_cnt + 16'h0001;
                end
                next_pwm_q = pwm_cnt < duty_cmp;
                if (tick || hpe_pkg::hpe_mode_e'(mode) != hpe_pkg::HPE_MODE_HW) begin
                    next_tick_cnt = 20'h00000;
                end else begin
                    next_tick_cnt = tick_cnt + 20'h00001;
                end
                if (state == hpe_pkg::HPE_SVC) begin
                    // Service window bounded by a fixed count
                    next_svc_cnt = svc_cnt + 7'h01;
                    if (svc_cnt == hpe_pkg::SVC_DUR - 7'h01) next_state = hpe_pkg::HPE_PLAY;
                end
                if (tick) begin
                    if (step == seq_len) begin
                        // Last step done: stop tick, PWM low, amplifier off
                        next_state = hpe_pkg::HPE_IDLE;
                        next_pwm_q = 1'b0;
                        next_amp_q = 1'b0;
                    end else begin
                        next_step    = step + 4'h1;
                        next_duty    = duty_mem[step + 4'h1];
                        next_state   = hpe_pkg::HPE_SVC;
                        next_svc_cnt = 7'h00;
                    end
                end
            end
            default: begin
                next_state = hpe_pkg::HPE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            aw_addr  <= 8'h00;
            w_data   <= 32'h0000_0000;
            w_strb   <= 4'h0;
            bvalid   <= 1'b0;
            bresp    <= 2'h0;
            rvalid   <= 1'b0;
            rdata    <= 32'h0000_0000;
            rresp    <= 2'h0;
            aw_rdy   <= 1'b1;
            w_rdy    <= 1'b1;
            ar_rdy   <= 1'b1;
            mode     <= hpe_pkg::CTRL_RESET;
            enable   <= hpe_pkg::ENABLE_RESET;
            seq_len  <= 4'h0;
            rejected <= 1'b0;
            for (int i = 0; i < int'(hpe_pkg::STEPS); i++) begin
                duty_mem[i] <= 8'h00;
            end
        end else begin
            aw_held  <= next_aw_held;
            w_held   <= next_w_held;
            aw_addr  <= next_aw_addr;
            w_data   <= next_w_data;
            w_strb   <= next_w_strb;
            bvalid   <= next_bvalid;
            bresp    <= next_bresp;
            rvalid   <= next_rvalid;
            rdata    <= next_rdata;
            rresp    <= next_rresp;
            aw_rdy   <= next_aw_rdy;
            w_rdy    <= next_w_rdy;
            ar_rdy   <= next_ar_rdy;
            mode     <= next_mode;
            enable   <= next_enable;
            seq_len  <= next_seq_len;
            rejected <= next_rejected;
            for (int i = 0; i < int'(hpe_pkg::STEPS); i++) begin
                duty_mem[i] <= next_duty_mem[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state    <= hpe_pkg::HPE_IDLE;
            effect   <= 4'h0;
            step     <= 4'h0;
            duty     <= 8'h00;
            pwm_cnt  <= 16'h0000;
            tick_cnt <= 20'h00000;
            svc_cnt  <= 7'h00;
            pwm_q    <= 1'b0;
            amp_q    <= 1'b0;
        end else begin
            state    <= next_state;
            effect   <= next_effect;
            step     <= next_step;
            duty     <= next_duty;
            pwm_cnt  <= next_pwm_cnt;
            tick_cnt <= next_tick_cnt;
            svc_cnt  <= next_svc_cnt;
            pwm_q    <= next_pwm_q;
            amp_q    <= next_amp_q;
        end
    end

    assign s_axi_awready            = aw_rdy;
    assign s_axi_wready             = w_rdy;
    assign s_axi_bvalid             = bvalid;
    assign s_axi_bresp              = bresp;
    assign s_axi_arready            = ar_rdy;
    assign s_axi_rvalid             = rvalid;
    assign s_axi_rdata              = rdata;
    assign s_axi_rresp              = rresp;
    assign duty_compare_output_out  = pwm_q;
    assign amplifier_shutdown_n_out = amp_q;
endmodule // hpe_player

/* File: dv/hpe_amp_model.sv */
// Amplifier and motor model that integrates the PWM drive it receives
module hpe_amp_model (
    input  wire logic clk_in,         // System clock
    input  wire logic clear_in,       // Restart the count
    input  wire logic pwm_in,         // PWM from the player
    input  wire logic shutdown_n_in,  // Amplifier enable
    output int        high_count_out, // Cycles of PWM high
    output int        stray_count_out // Cycles of PWM high while shut down
);
    timeunit 1ns;
    timeprecision 1ps;
    // Counts high cycles even in shutdown so a stray drive shows up in idle checks
    always @(posedge clk_in) begin
        if (clear_in) begin
            high_count_out <= 0;
        end else if (pwm_in) begin
            high_count_out <= high_count_out + 1;
        end
    end
    // Never cleared: drive into a shut-down amplifier anywhere in the run is kept
    always @(posedge clk_in) begin
        if (pwm_in && !shutdown_n_in) begin
            stray_count_out <= stray_count_out + 1;
        end
    end
endmodule // hpe_amp_model

/* File: dv/hpe_player_chk.sv */
// Checker for bus handshakes and amplifier drive of the effect player
module hpe_player_chk (
    input wire logic        clk_sys_in,               // Clock
    input wire logic        rst_in,                   // Reset
    input wire logic [7:0]  s_axi_awaddr,             // AW address
    input wire logic        s_axi_awvalid,            // AW valid
    input wire logic        s_axi_awready,            // AW ready
    input wire logic        s_axi_wvalid,             // W valid
    input wire logic        s_axi_wready,             // W ready
    input wire logic [1:0]  s_axi_bresp,              // B code
    input wire logic        s_axi_bvalid,             // B valid
    input wire logic        s_axi_bready,             // B ready
    input wire logic        s_axi_arvalid,            // AR valid
    input wire logic        s_axi_arready,            // AR ready
    input wire logic [31:0] s_axi_rdata,              // R data
    input wire logic        s_axi_rvalid,             // R valid
    input wire logic        s_axi_rready,             // R ready
    input wire logic        duty_compare_output_out,  // PWM
    input wire logic        amplifier_shutdown_n_out  // Amp enable
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire logic  pwm = duty_compare_output_out;
    wire logic  amp = amplifier_shutdown_n_out;
    logic [7:0] aw_addr;
    int         hi_run;
    logic       map_ok;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            aw_addr <= 8'h00;
            hi_run  <= 0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
            hi_run <= pwm ? hi_run + 1 : 0;
        end
    end
    // Status is read-only and refused like an unmapped word; duty entries must be aligned
    assign map_ok = aw_addr inside {8'h00, 8'h04, 8'h08, 8'h10}
                    || (aw_addr[7:6] == 2'h1 && aw_addr[1:0] == 2'h0);
    chk_pwm_shut: assert property (!amp |-> !pwm)
        else $error("PWM high while amplifier shut down");
    chk_pwm_width: assert property (hi_run < hpe_pkg::PWM_PERIOD_CYC)
        else $error("PWM high longer than one period");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped early");
    chk_aw_block: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("Second write address taken");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("Write response late");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late");
    chk_resp_code: assert property (s_axi_bvalid
        |-> s_axi_bresp == (map_ok ? hpe_pkg::RESP_OKAY : hpe_pkg::RESP_SLVERR))
        else $error("Wrong write response code");
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_play: cover property ($rose(amp));
    cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == hpe_pkg::RESP_SLVERR);
endmodule // hpe_player_chk

bind hpe_player hpe_player_chk hpe_player_chk_inst (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .duty_compare_output_out(duty_compare_output_out),
    .amplifier_shutdown_n_out(amplifier_shutdown_n_out)
);

/* File: dv/tb_hpe_player.sv */
// Self-checking bench of the haptic effect player
module tb_hpe_player;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
    logic        clk_sys_in = 1'h0;
    logic        rst_in = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0;
    logic        clr = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        pwm, amp;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    int          miscompares = 0;
    int          check_count = 0;
    int          high_cnt, stray_cnt, enables, duty, len, ok, eff, pick;

    always #20 clk_sys_in = ~clk_sys_in;

    hpe_player hpe_player_inst (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rready(s_axi_rready),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .duty_compare_output_out(pwm), .amplifier_shutdown_n_out(amp)
    );
    hpe_amp_model hpe_amp_model_inst (
        .clk_in(clk_sys_in), .clear_in(clr), .pwm_in(pwm), .shutdown_n_in(amp),
        .high_count_out(high_cnt), .stray_count_out(stray_cnt)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge clk_sys_in);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_in);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        // A late ready makes the slave hold its response
        repeat ($urandom_range(2, 0)) @(posedge clk_sys_in);
        s_axi_bready <= 1'h1;
        do @(posedge clk_sys_in); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys_in);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk_sys_in); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        // A late ready makes the slave hold its read data
        repeat ($urandom_range(2, 0)) @(posedge clk_sys_in);
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys_in); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // One whole PWM period, so the count does not depend on phase
    task automatic measure();
        clr <= 1'h1;
        @(posedge clk_sys_in);
        clr <= 1'h0;
        repeat (hpe_pkg::PWM_PERIOD_CYC + 1) @(posedge clk_sys_in);
    endtask

    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(41844));
        repeat (5) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        rdr(hpe_pkg::REG_CTRL);
        `CHK("ctrl", 32'h0000_0000, rd)
        `CHK("amp", 1'h0, amp)
        wr(8'h20, 32'h0000_0001);
        `CHK("wr_resp", hpe_pkg::RESP_SLVERR, resp)
        wr(8'h42, 32'h0000_0001);
        `CHK("wr_unaligned", hpe_pkg::RESP_SLVERR, resp)
        rdr(8'h24);
        `CHK("rd_resp", hpe_pkg::RESP_SLVERR, resp)
        enables = $urandom & 32'h0000_3FFF;
        pick = $urandom_range(13, 0);
        enables[pick] = 1'h1;
        wr(hpe_pkg::REG_ENABLE, 32'(enables));
        rdr(hpe_pkg::REG_ENABLE);
        `CHK("enable", enables[13:0], rd[13:0])
        // Upper enable byte is masked off by its strobe and must keep its value
        s_axi_wstrb <= 4'h1;
        wr(hpe_pkg::REG_ENABLE, 32'(enables) ^ 32'h0000_3F00);
        s_axi_wstrb <= 4'hF;
        rdr(hpe_pkg::REG_ENABLE);
        `CHK("enable_strb", enables[13:0], rd[13:0])
        duty = $urandom_range(255, 1);
        for (int i = 0; i < hpe_pkg::STEPS; i++) begin
            wr(hpe_pkg::REG_DUTY_BASE + 8'(4 * i), 32'(duty));
        end
        for (eff = 0; eff < 16; eff++) begin
            len = $urandom_range(3, 1);
            wr(hpe_pkg::REG_CTRL, 32'(1 + eff % 2 + len * 16));
            ok = (eff < hpe_pkg::NUM_EFFECTS) && enables[eff];
            wr(hpe_pkg::REG_PLAY, 32'(eff));
            repeat (3) @(posedge clk_sys_in);
            rdr(hpe_pkg::REG_STATUS);
            `CHK("busy", ok[0], rd[0])
            `CHK("reject", !ok[0], rd[1])
            `CHK("amp", ok[0], amp)
            if (ok) begin
                measure();
                `CHK("high_time", duty * hpe_pkg::PWM_PERIOD_CYC / 256, high_cnt)
                wr(hpe_pkg::REG_PLAY, 32'((eff + 1) % 14));
                for (int k = 1; k <= len + 1; k++) begin
                    wr(hpe_pkg::REG_UPDATE, 32'h0000_0001);
                    repeat (100) @(posedge clk_sys_in);
                    rdr(hpe_pkg::REG_STATUS);
                    `CHK("playing", (k <= len), amp)
                    `CHK("busy", (k <= len), rd[0])
                    if (k <= len) `CHK("step", 4'(k), rd[7:4])
                    if (k <= len) `CHK("effect", eff[3:0], rd[11:8])
                end
            end
        end
        measure();
        `CHK("idle_pwm", 0, high_cnt)
        wr(hpe_pkg::REG_CTRL, 32'h0000_0010);
        wr(hpe_pkg::REG_PLAY, 32'(pick));
        wr(hpe_pkg::REG_UPDATE, 32'h0000_0001);
        repeat (200) @(posedge clk_sys_in);
        `CHK("hw_amp", 1'h1, amp)
        rdr(hpe_pkg::REG_STATUS);
        `CHK("hw_step", 4'h0, rd[7:4])
        rst_in <= 1'h1;
        repeat (5) @(posedge clk_sys_in);
        `CHK("rst_amp", 1'h0, amp)
        `CHK("rst_pwm", 1'h0, pwm)
        rst_in <= 1'h0;
        rdr(hpe_pkg::REG_ENABLE);
        `CHK("enable", 32'h0000_0000, rd)
        `CHK("stray_drive", 0, stray_cnt)
        complete_run();
    end

    // Full run needs at most some 24000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys_in);
        miscompares++;
        complete_run();
    end
endmodule // tb_hpe_player
